// *** sfrp_pkg.sv ***
// constants and types shared by both ends of the fifo read port
package sfrp_pkg;

  // data path and fifo geometry
  localparam int DATA_W    = 16;
  localparam int SEL_W     = 2;
  localparam int NUM_FIFOS = 4;
  localparam int PTR_W     = 4;
  localparam int DEPTH     = 16;
  localparam int CNT_W     = 8;
  localparam int MEM_W     = SEL_W + PTR_W;

  // link timing, in ns as given
  localparam int LINK_PERIOD_NS  = 160;
  localparam int SELECT_SETUP_NS = 25;
  localparam int STROBE_LOW_NS   = 50;
  localparam int STROBE_HIGH_NS  = 50;

  // least times round up, never below one cycle
  function automatic int sfrp_min_cycles(input int ns);
    int c;
    c = (ns + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : sfrp_min_cycles

  localparam int SELECT_SETUP_CYC = sfrp_min_cycles(SELECT_SETUP_NS);
  localparam int STROBE_LOW_CYC   = sfrp_min_cycles(STROBE_LOW_NS);
  localparam int STROBE_HIGH_CYC  = sfrp_min_cycles(STROBE_HIGH_NS);
  localparam int TMR_W            = 4;

  // mode bit and inactive pin level
  localparam logic MODE_SYNC = 1'b1;
  localparam logic PIN_IDLE  = 1'b1;

  // master sequencer states
  typedef enum logic [2:0] {
    SFRP_IDLE,
    SFRP_SELECT,
    SFRP_ENABLE,
    SFRP_STROBE,
    SFRP_GAP,
    SFRP_WAIT,
    SFRP_DONE
  } sfrp_host_state_t;

endpackage : sfrp_pkg

// *** sfrp_link_if.sv ***
// pins between the fifo port device and its master
`timescale 1ns/100ps
`default_nettype none
interface sfrp_link_if (
  input wire logic interface_clock
);
  import sfrp_pkg::*;

  logic [SEL_W-1:0]  fifo_select_lines;
  logic              port_select_n;
  logic              bus_output_enable_n;
  logic              read_strobe_n;
  logic [DATA_W-1:0] dev_data;
  logic              dev_data_oe;
  logic [DATA_W-1:0] data_bus;

  // resolved bus level; reads zero while nobody drives it
  assign data_bus = dev_data_oe ? dev_data : '0;

  modport dev (
    input  interface_clock,
    input  fifo_select_lines,
    input  port_select_n,
    input  bus_output_enable_n,
    input  read_strobe_n,
    output dev_data,
    output dev_data_oe
  );

  modport host (
    input  interface_clock,
    output fifo_select_lines,
    output port_select_n,
    output bus_output_enable_n,
    output read_strobe_n,
    input  data_bus
  );
endinterface : sfrp_link_if
`default_nettype wire

// *** sfrp_device.sv ***
// device end: fifo storage and slave read port on the link clock
`timescale 1ns/100ps
`default_nettype none

// Function
// - master sets select lines before clock edge
// - output enable only switches data drivers
// - sync mode prefetches word at pointer
// - master meets strobe setup and hold
// - valid read needs select and strobe
// - sync mode advances pointer per valid edge
// - data driven only while enable asserted; drivers here follow the enable one cycle late
// - sync burst increments pointer every edge
// - async enable alone shows leftover word
// - master keeps async strobe pulse widths
// - async strobe shows new word, then increments
// - strobe and enable may be tied
// - select may stay tied low
// - async pulses and gaps at least 50 ns
module sfrp_device (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic                      sync_mode,
  input  wire logic                      fill_valid,
  output logic                           fill_ready,
  input  wire logic [sfrp_pkg::SEL_W-1:0]  fill_fifo,
  input  wire logic [sfrp_pkg::DATA_W-1:0] fill_word,
  sfrp_link_if.dev                       link
);
  import sfrp_pkg::*;

  // system side of the fill handshake
  logic              fill_req;
  logic [SEL_W-1:0]  fill_sel_hold;
  logic [DATA_W-1:0] fill_word_hold;
  logic              fill_ack_s1;
  logic              fill_ack_s2;

  // link side of the fill handshake and mode crossing
  logic              fill_req_s1;
  logic              fill_req_s2;
  logic              fill_seen;
  logic              mode_s1;
  logic              mode_s2;

  // fifo storage and per-fifo bookkeeping
  logic [DATA_W-1:0] mem [NUM_FIFOS*DEPTH];
  logic [PTR_W-1:0]  rd_ptr [NUM_FIFOS];
  logic [PTR_W-1:0]  wr_ptr [NUM_FIFOS];
  logic [PTR_W:0]    fill_cnt [NUM_FIFOS];

  // read port state
  logic              strobe_seen;
  logic [DATA_W-1:0] data_q;
  logic              oe_q;

  // decoded link terms
  wire               fill_accept;
  wire               new_fill;
  wire               do_write;
  wire               valid_read;
  wire               sel_nonempty;
  wire               next_has_word;
  wire               advance;
  wire [PTR_W-1:0]   cur_ptr;
  wire [PTR_W-1:0]   next_ptr;
  wire [MEM_W-1:0]   cur_addr;
  wire [MEM_W-1:0]   next_addr;
  wire [MEM_W-1:0]   wr_addr;
  wire [DATA_W-1:0]  next_data;

  // ---------------- system clock domain ----------------

  assign fill_accept = fill_valid & fill_ready;

  // word is held steady until the link side returns the toggle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_req       <= 1'b0;
      fill_sel_hold  <= '0;
      fill_word_hold <= '0;
    end else if (fill_accept) begin
      fill_req       <= ~fill_req;
      fill_sel_hold  <= fill_fifo;
      fill_word_hold <= fill_word;
    end
  end

  // ack toggle back from the link clock, two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_ack_s1 <= 1'b0;
      fill_ack_s2 <= 1'b0;
    end else begin
      fill_ack_s1 <= fill_seen;
      fill_ack_s2 <= fill_ack_s1;
    end
  end

  // ready again once the toggle has come round
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_ready <= 1'b0;
    end else if (fill_accept) begin
      fill_ready <= 1'b0;
    end else begin
      fill_ready <= (fill_ack_s2 == fill_req);
    end
  end

  // ---------------- link clock domain ----------------

  // request toggle and mode level pass two flops each
  always_ff @(posedge link.interface_clock or negedge arst_n) begin
    if (!arst_n) begin
      fill_req_s1 <= 1'b0;
      fill_req_s2 <= 1'b0;
      mode_s1     <= 1'b0;
      mode_s2     <= 1'b0;
    end else begin
      fill_req_s1 <= fill_req;
      fill_req_s2 <= fill_req_s1;
      mode_s1     <= sync_mode;
      mode_s2     <= mode_s1;
    end
  end

  // a word into a full fifo is dropped, never overwrites
  assign new_fill = fill_req_s2 != fill_seen;
  assign do_write = new_fill &&
                    (fill_cnt[fill_sel_hold] != (PTR_W+1)'(DEPTH));
  assign wr_addr  = {fill_sel_hold, wr_ptr[fill_sel_hold]};

  // pins are launched on this same clock, no resync needed
  assign valid_read   = ~link.port_select_n &
                        ~link.read_strobe_n;
  assign sel_nonempty = fill_cnt[link.fifo_select_lines] != '0;

  // sync: every edge with a valid read; async: only the
  // activating edge of the strobe
  assign advance = valid_read & sel_nonempty &
                   ((mode_s2 == MODE_SYNC) | ~strobe_seen);

  assign cur_ptr   = rd_ptr[link.fifo_select_lines];
  assign next_ptr  = cur_ptr + PTR_W'(advance);
  assign cur_addr  = {link.fifo_select_lines, cur_ptr};
  assign next_addr = {link.fifo_select_lines, next_ptr};

  // a drained fifo keeps the old word, so unfilled storage
  // never reaches the pins
  assign next_has_word = fill_cnt[link.fifo_select_lines] !=
                         (PTR_W+1)'(advance);

  // sync shows the word at the pointer after this edge;
  // async keeps the last word until a new strobe
  assign next_data = (mode_s2 == MODE_SYNC) ?
                     (next_has_word ? mem[next_addr] : data_q) :
                     advance ? mem[cur_addr] :
                     data_q;

  // handshake bookkeeping
  always_ff @(posedge link.interface_clock or negedge arst_n) begin
    if (!arst_n) begin
      fill_seen <= 1'b0;
    end else if (new_fill) begin
      fill_seen <= fill_req_s2;
    end
  end

  // storage has no reset, contents are undefined until filled
  always_ff @(posedge link.interface_clock) begin
    if (do_write) begin
      mem[wr_addr] <= fill_word_hold;
    end
  end

  // pointers and counts, one copy per fifo
  for (genvar i = 0; i < NUM_FIFOS; i++) begin : g_fifo
    wire wr_here;
    wire rd_here;
    assign wr_here = do_write && (fill_sel_hold == SEL_W'(i));
    assign rd_here = advance &&
                     (link.fifo_select_lines == SEL_W'(i));

    always_ff @(posedge link.interface_clock or negedge arst_n) begin
      if (!arst_n) begin
        rd_ptr[i]   <= '0;
        wr_ptr[i]   <= '0;
        fill_cnt[i] <= '0;
      end else begin
        rd_ptr[i]   <= rd_ptr[i] + PTR_W'(rd_here);
        wr_ptr[i]   <= wr_ptr[i] + PTR_W'(wr_here);
        fill_cnt[i] <= fill_cnt[i] + (PTR_W+1)'(wr_here)
                       - (PTR_W+1)'(rd_here);
      end
    end
  end

  // remembers the strobe level so async sees one edge
  // per pulse, which also covers a tied strobe and enable
  always_ff @(posedge link.interface_clock or negedge arst_n) begin
    if (!arst_n) begin
      strobe_seen <= 1'b0;
    end else begin
      strobe_seen <= valid_read;
    end
  end

  // data register follows the pointer, not the enable
  always_ff @(posedge link.interface_clock or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= '0;
    end else begin
      data_q <= next_data;
    end
  end

  // enable only steers the drivers, one cycle behind the pin
  always_ff @(posedge link.interface_clock or negedge arst_n) begin
    if (!arst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~link.bus_output_enable_n;
    end
  end

  assign link.dev_data    = data_q;
  assign link.dev_data_oe = oe_q;

endmodule : sfrp_device
`default_nettype wire

// *** sfrp_host.sv ***
// master end: issues fifo reads on the link clock
`timescale 1ns/100ps
`default_nettype none
module sfrp_host (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic                      cmd_valid,
  output logic                           cmd_ready,
  input  wire logic [sfrp_pkg::SEL_W-1:0]  cmd_fifo,
  input  wire logic [sfrp_pkg::CNT_W-1:0]  cmd_count,
  input  wire logic                      cmd_sync,
  output logic                           word_valid,
  output logic [sfrp_pkg::DATA_W-1:0]    word_data,
  sfrp_link_if.host                      link
);
  import sfrp_pkg::*;

  // system domain
  logic              cmd_req;
  logic [SEL_W-1:0]  cmd_fifo_hold;
  logic [CNT_W-1:0]  cmd_count_hold;
  logic              cmd_sync_hold;
  logic              cmd_ack_s1;
  logic              cmd_ack_s2;
  logic              word_s1;
  logic              word_s2;
  logic              word_seen;

  // link domain
  sfrp_host_state_t  state;
  logic              cmd_s1;
  logic              cmd_s2;
  logic              cmd_done;
  logic              wack_s1;
  logic              wack_s2;
  logic              word_req;
  logic [DATA_W-1:0] word_hold;
  logic [CNT_W-1:0]  remaining;
  logic [TMR_W-1:0]  timer;
  logic              mode;
  logic [SEL_W-1:0]  sel;
  logic              cs_n;
  logic              oe_n;
  logic              rd_n;

  wire cmd_accept = cmd_valid & cmd_ready;
  wire new_cmd    = cmd_s2 != cmd_done;
  wire word_free  = wack_s2 == word_req;
  wire new_word   = word_s2 != word_seen;

  // command held steady while the link runs it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_req        <= 1'b0;
      cmd_fifo_hold  <= '0;
      cmd_count_hold <= '0;
      cmd_sync_hold  <= 1'b0;
      cmd_ready      <= 1'b0;
    end else if (cmd_accept) begin
      cmd_req        <= ~cmd_req;
      cmd_fifo_hold  <= cmd_fifo;
      cmd_count_hold <= cmd_count;
      cmd_sync_hold  <= cmd_sync;
      cmd_ready      <= 1'b0;
    end else begin
      cmd_ready      <= cmd_ack_s2 == cmd_req;
    end
  end

  // toggles from the link clock, two flops each
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ack_s1 <= 1'b0;
      cmd_ack_s2 <= 1'b0;
      word_s1    <= 1'b0;
      word_s2    <= 1'b0;
    end else begin
      cmd_ack_s1 <= cmd_done;
      cmd_ack_s2 <= cmd_ack_s1;
      word_s1    <= word_req;
      word_s2    <= word_s1;
    end
  end

  // one pulse per word; word_hold is stable until acked
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_seen  <= 1'b0;
      word_valid <= 1'b0;
      word_data  <= '0;
    end else begin
      word_valid <= new_word;
      if (new_word) begin
        word_seen <= word_s2;
        word_data <= word_hold;
      end
    end
  end

  // link side crossings
  always_ff @(posedge link.interface_clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_s1  <= 1'b0;
      cmd_s2  <= 1'b0;
      wack_s1 <= 1'b0;
      wack_s2 <= 1'b0;
    end else begin
      cmd_s1  <= cmd_req;
      cmd_s2  <= cmd_s1;
      wack_s1 <= word_seen;
      wack_s2 <= wack_s1;
    end
  end

  // read sequencer; strobe stays high while a word waits
  // for the system side, trading burst rate for no buffer
  always_ff @(posedge link.interface_clock or negedge arst_n) begin
    if (!arst_n) begin
      state     <= SFRP_IDLE;
      cmd_done  <= 1'b0;
      word_req  <= 1'b0;
      word_hold <= '0;
      remaining <= '0;
      timer     <= '0;
      mode      <= 1'b0;
      sel       <= '0;
      cs_n      <= PIN_IDLE;
      oe_n      <= PIN_IDLE;
      rd_n      <= PIN_IDLE;
    end else begin
      case (state)
        SFRP_IDLE: begin
          if (new_cmd) begin
            sel       <= cmd_fifo_hold;
            remaining <= cmd_count_hold;
            mode      <= cmd_sync_hold;
            cs_n      <= 1'b0;
            timer     <= TMR_W'(SELECT_SETUP_CYC);
            state     <= SFRP_SELECT;
          end
        end
        SFRP_SELECT: begin
          if (timer <= TMR_W'(1)) begin
            oe_n  <= 1'b0;
            state <= SFRP_ENABLE;
          end else begin
            timer <= timer - TMR_W'(1);
          end
        end
        SFRP_ENABLE: begin
          if (remaining == '0) begin
            state <= SFRP_DONE;
          end else begin
            rd_n  <= 1'b0;
            timer <= TMR_W'(STROBE_LOW_CYC);
            state <= SFRP_STROBE;
          end
        end
        SFRP_STROBE: begin
          if (mode == MODE_SYNC) begin
            word_hold <= link.data_bus;
            word_req  <= ~word_req;
            remaining <= remaining - CNT_W'(1);
            rd_n      <= 1'b1;
            timer     <= TMR_W'(1);
            state     <= SFRP_WAIT;
          end else if (timer <= TMR_W'(1)) begin
            rd_n  <= 1'b1;
            timer <= TMR_W'(STROBE_HIGH_CYC);
            state <= SFRP_GAP;
          end else begin
            timer <= timer - TMR_W'(1);
          end
        end
        SFRP_GAP: begin
          word_hold <= link.data_bus;
          word_req  <= ~word_req;
          remaining <= remaining - CNT_W'(1);
          state     <= SFRP_WAIT;
        end
        SFRP_WAIT: begin
          if (timer > TMR_W'(1)) begin
            timer <= timer - TMR_W'(1);
          end else if (word_free) begin
            if (remaining == '0) begin
              state <= SFRP_DONE;
            end else begin
              rd_n  <= 1'b0;
              timer <= TMR_W'(STROBE_LOW_CYC);
              state <= SFRP_STROBE;
            end
          end
        end
        SFRP_DONE: begin
          oe_n     <= PIN_IDLE;
          cs_n     <= PIN_IDLE;
          cmd_done <= cmd_s2;
          state    <= SFRP_IDLE;
        end
        default: begin
          state <= SFRP_IDLE;
        end
      endcase
    end
  end

  assign link.fifo_select_lines   = sel;
  assign link.port_select_n       = cs_n;
  assign link.bus_output_enable_n = oe_n;
  assign link.read_strobe_n       = rd_n;

endmodule : sfrp_host
`default_nettype wire

// *** sfrp_sva.sv ***
// link-side protocol checks for the fifo read port
`timescale 1ns/100ps
`default_nettype none
module sfrp_sva (
  input wire logic                        interface_clock,
  input wire logic                        arst_n,
  input wire logic [sfrp_pkg::SEL_W-1:0]  fifo_select_lines,
  input wire logic                        port_select_n,
  input wire logic                        bus_output_enable_n,
  input wire logic                        read_strobe_n,
  input wire logic [sfrp_pkg::DATA_W-1:0] dev_data,
  input wire logic                        dev_data_oe,
  input wire logic [sfrp_pkg::DATA_W-1:0] data_bus
);
  import sfrp_pkg::*;

  // all link checks live on the link clock
  default clocking link_cb @(posedge interface_clock);
  endclocking
  default disable iff (!arst_n);

  // drivers stay off while the enable has been high for two edges
  oe_off_a: assert property (
    bus_output_enable_n && $past(bus_output_enable_n)
    |-> !dev_data_oe && data_bus == '0)
    else $error("data driven with output enable released");

  // prefetched word reaches the bus one edge after enable falls
  oe_on_a: assert property (
    $fell(bus_output_enable_n) |=> dev_data_oe && data_bus == dev_data)
    else $error("data not driven after output enable");

  // two quiet edges of slack: port data lags the sampled strobe by one edge
  data_hold_a: assert property (
    read_strobe_n && $past(read_strobe_n) && $past(read_strobe_n, 2)
    && !port_select_n && !$past(port_select_n) && !$past(port_select_n, 2)
    |-> $stable(dev_data))
    else $error("port word changed without a read");

  sel_first_a: assert property (
    $fell(read_strobe_n) |-> !port_select_n && !$past(port_select_n))
    else $error("strobe not preceded by chip select");

  oe_first_a: assert property (
    $fell(read_strobe_n) |-> !$past(bus_output_enable_n))
    else $error("strobe not preceded by output enable");

  idle_pins_a: assert property (
    port_select_n |-> read_strobe_n && bus_output_enable_n)
    else $error("control active while port deselected");

  addr_hold_a: assert property (
    !port_select_n && !$past(port_select_n) |-> $stable(fifo_select_lines))
    else $error("fifo number moved while selected");

  // a command on a filled fifo must not hang the link
  cmd_bound_a: assert property (
    $fell(port_select_n) |-> ##[1:1000] port_select_n)
    else $error("port stayed selected too long");

  burst_c: cover property ($fell(read_strobe_n) ##[2:40] $fell(read_strobe_n));
endmodule : sfrp_sva
`default_nettype wire

// *** sfrp_tb.sv ***
// self-checking bench: host and device joined over the fifo read link
`timescale 1ns/100ps
`default_nettype none
module sfrp_tb;
  import sfrp_pkg::*;

  logic              sys_clk;
  logic              interface_clock;
  logic              arst_n;
  logic              sync_mode;
  logic              fill_valid;
  logic              fill_ready;
  logic [SEL_W-1:0]  fill_fifo;
  logic [DATA_W-1:0] fill_word;
  logic              cmd_valid;
  logic              cmd_ready;
  logic [SEL_W-1:0]  cmd_fifo;
  logic [CNT_W-1:0]  cmd_count;
  logic              cmd_sync;
  logic              word_valid;
  logic [DATA_W-1:0] word_data;
  int                miscompares;
  int                n_compared;
  int                wr_idx [NUM_FIFOS];
  int                rd_idx [NUM_FIFOS];

  sfrp_link_if link_if (.interface_clock(interface_clock));

  sfrp_device sfrp_device_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .sync_mode(sync_mode),
    .fill_valid(fill_valid), .fill_ready(fill_ready),
    .fill_fifo(fill_fifo), .fill_word(fill_word), .link(link_if));

  sfrp_host sfrp_host_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_fifo(cmd_fifo), .cmd_count(cmd_count),
    .cmd_sync(cmd_sync), .word_valid(word_valid),
    .word_data(word_data), .link(link_if));

  sfrp_sva sfrp_sva_inst (
    .interface_clock(interface_clock), .arst_n(arst_n),
    .fifo_select_lines(link_if.fifo_select_lines),
    .port_select_n(link_if.port_select_n),
    .bus_output_enable_n(link_if.bus_output_enable_n),
    .read_strobe_n(link_if.read_strobe_n), .dev_data(link_if.dev_data),
    .dev_data_oe(link_if.dev_data_oe), .data_bus(link_if.data_bus));

  // system clock, 100 ns
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // link clock, 160 ns, offset so its edges drift against the system ones
  initial begin
    interface_clock = 1'b0;
    #37;
    forever #80 interface_clock = ~interface_clock;
  end

  // distinct word per fifo and position, so order slips show
  function automatic logic [DATA_W-1:0] word_of(input int f, input int i);
    return DATA_W'(32'h5a00 + f * 16 + i);
  endfunction : word_of

  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // a wait that ran out counts as a mismatch
  task automatic limit_hit(input int w, input int lim);
    if (w >= lim) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, w, lim);
    end
  endtask : limit_hit

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // one word per handshake; ready drops after the take, so wait it out
  task automatic fill_n(input int f, input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      w = 0;
      while (fill_ready !== 1'b1 && w < 200) begin
        @(negedge sys_clk);
        w++;
      end
      limit_hit(w, 200);
      fill_valid = 1'b1;
      fill_fifo  = SEL_W'(f);
      fill_word  = word_of(f, wr_idx[f]);
      wr_idx[f]++;
      @(negedge sys_clk);
      fill_valid = 1'b0;
      @(negedge sys_clk);
    end
  endtask : fill_n

  // one host command; words must come in fifo order and nothing extra
  task automatic run_cmd(input int f, input int cnt, input logic sy);
    int got;
    int w;
    got = 0;
    sync_mode = sy;
    repeat (8) @(negedge sys_clk);
    w = 0;
    while (cmd_ready !== 1'b1 && w < 200) begin
      @(negedge sys_clk);
      w++;
    end
    limit_hit(w, 200);
    cmd_valid = 1'b1;
    cmd_fifo  = SEL_W'(f);
    cmd_count = CNT_W'(cnt);
    cmd_sync  = sy;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    w = 0;
    while ((got < cnt || cmd_ready !== 1'b1 || w < 4) && w < 3000) begin
      @(negedge sys_clk);
      w++;
      if (word_valid === 1'b1) begin
        chk(word_data, word_of(f, rd_idx[f]));
        rd_idx[f]++;
        got++;
      end
    end
    limit_hit(w, 3000);
    chk(DATA_W'(got), DATA_W'(cnt));
    repeat (3) @(negedge sys_clk);
    chk(DATA_W'({link_if.port_select_n, link_if.bus_output_enable_n,
                 link_if.read_strobe_n}), 16'h0007);
    chk(link_if.data_bus, 16'h0000);
  endtask : run_cmd

  // every fifo number, modes alternating
  task automatic t_all_fifos();
    for (int f = 0; f < NUM_FIFOS; f++) fill_n(f, 2);
    for (int f = NUM_FIFOS - 1; f >= 0; f--) run_cmd(f, 2, 1'(f % 2));
    $display("test all_fifos done");
  endtask : t_all_fifos

  // single read, enable-only pass, then a burst, synchronous
  task automatic t_sync();
    fill_n(1, 6);
    run_cmd(1, 1, 1'b1);
    run_cmd(1, 0, 1'b1);
    run_cmd(1, 5, 1'b1);
    $display("test sync done");
  endtask : t_sync

  // the same sequence in asynchronous mode
  task automatic t_async();
    fill_n(2, 5);
    run_cmd(2, 1, 1'b0);
    run_cmd(2, 0, 1'b0);
    run_cmd(2, 4, 1'b0);
    $display("test async done");
  endtask : t_async

  // main sequence
  initial begin
    arst_n      = 1'b0;
    sync_mode   = 1'b1;
    fill_valid  = 1'b0;
    fill_fifo   = '0;
    fill_word   = '0;
    cmd_valid   = 1'b0;
    cmd_fifo    = '0;
    cmd_count   = '0;
    cmd_sync    = 1'b1;
    miscompares = 0;
    n_compared  = 0;
    wr_idx      = '{default: 0};
    rd_idx      = '{default: 0};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_all_fifos();
    t_sync();
    t_async();
    tally_and_finish();
  end

  // watchdog, well past the expected few tens of microseconds
  initial begin
    #2000000;
    miscompares++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule : sfrp_tb
`default_nettype wire
